// *** core/bcf_channel.sv ***
// bcf_channel: control, enable and fault protection of one bus master channel.
// assumes register accesses arrive already decoded from the serial port, and
// that the protocol engine on the same clk reports frame events and bit ticks.
`include "bcf_map.svh"
`default_nettype none
module bcf_channel #(
   parameter bit CHANNEL_ZERO = 1'b1,
   parameter int THERM_FILT_CYC = `BCF_THERM_FILT_CYC
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic reg_wr,
   input wire logic reg_sel,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic [7:0] status_byte,
   input wire logic idle_overcurrent,
   input wire logic driver_thermal,
   input wire logic switch_thermal,
   input wire logic frame_active,
   input wire logic frame_end,
   input wire logic frame_done,
   input wire logic frame_overcurrent,
   input wire logic bit_tick,
   input wire logic rx_crc_error,
   input wire logic tx_empty,
   input wire logic signal_shutdown_frame,
   input wire logic rx_not_empty,
   output logic driver_enable,
   output logic loopback_active,
   output logic bus_high_switch,
   output logic bus_low_switch,
   output logic buffers_reset,
   output logic transfer_abort,
   output logic message_size_select,
   output logic [1:0] interframe_gap_select,
   output logic gap_ok
);
   localparam int TW = $clog2(THERM_FILT_CYC + 1);
   bcf_pkg::bcf_byte_t ctrl;
   bcf_pkg::bcf_byte_t applied;
   bcf_pkg::bcf_bits_t gap_cnt;
   logic en, ts, signal_shutdown_disable_flag, idle_current_limit_flag;
   logic next_en;
   logic ctrl_wr, en_wr, loop_on;
   logic t1, t2, t3, tlvl, therm_done, therm_evt;
   logic w1, w2, w3, sw_therm;
   logic [TW-1:0] therm_cnt;
   logic [1:0] sig_cnt;
   logic sig_trip;
   logic prev_oc_frame;
   bcf_fault_if fif ();

   // gap select code to bit times
   function automatic bcf_pkg::bcf_bits_t gap_bits(input logic [1:0] sel);
      unique case (sel)
         2'h0: gap_bits = `BCF_GAP_SEL0;
         2'h1: gap_bits = `BCF_GAP_SEL1;
         2'h2: gap_bits = `BCF_GAP_SEL2;
         2'h3: gap_bits = `BCF_GAP_SEL3;
      endcase
   endfunction

   // write decode and loopback decode
   assign ctrl_wr = reg_wr && (reg_sel == `BCF_SEL_CTRL);
   assign en_wr = reg_wr && (reg_sel == `BCF_SEL_EN);
   assign loop_on = (ctrl[`BCF_CTRL_LOOP_HI:`BCF_CTRL_LOOP_LO] == `BCF_LOOP_ON);

   // idle fault monitor, armed only while the bus is driven
   assign fif.arm = en && !loop_on && !idle_current_limit_flag && !ts && !signal_shutdown_disable_flag;
   bcf_idle_fault u_idle (
      .clk(clk),
      .resetn(resetn),
      .idle_overcurrent(idle_overcurrent),
      .fif(fif)
   );

   // synchronisers for the two thermal limit pins
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         t1 <= 1'b0;
         t2 <= 1'b0;
         t3 <= 1'b0;
         tlvl <= 1'b0;
         w1 <= 1'b0;
         w2 <= 1'b0;
         w3 <= 1'b0;
         sw_therm <= 1'b0;
      end else begin
         t1 <= driver_thermal;
         t2 <= t1;
         t3 <= t2;
         if (t2 == t3) begin
            tlvl <= t3;
         end
         w1 <= switch_thermal;
         w2 <= w1;
         w3 <= w2;
         if (w2 == w3) begin
            sw_therm <= w3;
         end
      end
   end

   // thermal filter: one event per limit episode after the filter time
   assign therm_evt = tlvl && !therm_done && (therm_cnt == TW'(THERM_FILT_CYC - 1));
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         therm_cnt <= '0;
         therm_done <= 1'b0;
      end else if (!tlvl) begin
         therm_cnt <= '0;
         therm_done <= 1'b0;
      end else if (therm_evt) begin
         therm_done <= 1'b1;
      end else if (!therm_done) begin
         therm_cnt <= therm_cnt + TW'(1);
      end
   end

   // signal-mode over-current over consecutive frames
   assign sig_trip = en && frame_done && frame_overcurrent
                     && (sig_cnt == 2'(`BCF_SIG_OC_FRAMES - 1));
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sig_cnt <= 2'h0;
      end else if (therm_evt || !en || sig_trip) begin
         sig_cnt <= 2'h0;
      end else if (frame_done) begin
         sig_cnt <= frame_overcurrent ? sig_cnt + 2'h1 : 2'h0;
      end
   end

   // control register: written by host, cleared by thermal shutdown
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl <= `BCF_CTRL_RESET;
      end else if (therm_evt) begin
         ctrl <= `BCF_CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl <= reg_wdata & 8'h37; // reserved bits stay zero
      end
   end

   // message size and gap settings reach the engine only between transactions; thermal shutdown resets them at once, even mid-frame
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         applied <= `BCF_CTRL_RESET;
      end else if (therm_evt) begin
         applied <= `BCF_CTRL_RESET;
      end else if (!frame_active) begin
         applied <= ctrl;
      end
   end

   // enable next value: thermal and signal over-current faults and loopback win over a host write
   always_comb begin
      next_en = en;
      if (therm_evt || sig_trip || loop_on) begin
         next_en = 1'b0;
      end else if (en_wr) begin
         next_en = reg_wdata[`BCF_EN_EN];
      end
   end

   // enable bit
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         en <= 1'b0; // enable bit of the all-zero enable register reset
      end else begin
         en <= next_en;
      end
   end

   // thermal flag: set wins, host clears by writing zero
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ts <= 1'b0;
      end else if (therm_evt) begin
         ts <= 1'b1;
      end else if (en_wr && !reg_wdata[`BCF_EN_TS]) begin
         ts <= 1'b0;
      end
   end

   // signal shutdown flag: thermal shutdown clears it, else set wins; host clears by writing zero
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         signal_shutdown_disable_flag <= 1'b0;
      end else if (therm_evt) begin
         signal_shutdown_disable_flag <= 1'b0;
      end else if (sig_trip) begin
         signal_shutdown_disable_flag <= 1'b1;
      end else if (en_wr && !reg_wdata[`BCF_EN_SIGNAL_SHUTDOWN_DISABLE_FLAG]) begin
         signal_shutdown_disable_flag <= 1'b0;
      end
   end

   // channel zero bus switches
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bus_high_switch <= 1'b0;
         bus_low_switch <= 1'b0;
      end else if (!CHANNEL_ZERO || therm_evt || sig_trip || sw_therm || !next_en) begin
         bus_high_switch <= 1'b0;
         bus_low_switch <= 1'b0;
      end else if (en_wr) begin
         bus_high_switch <= reg_wdata[`BCF_EN_HIGH];
         bus_low_switch <= reg_wdata[`BCF_EN_LOW];
      end
   end

   // idle current-limit flag, held until disable or reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         idle_current_limit_flag <= 1'b0;
      end else if (fif.trip && fif.arm) begin
         idle_current_limit_flag <= 1'b1;
      end else if (!en || therm_evt) begin
         idle_current_limit_flag <= 1'b0;
      end
   end

   // interframe gap counter in bit times from frame end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         gap_cnt <= `BCF_GAP_MAX;
         gap_ok <= 1'b1;
      end else begin
         if (frame_end) begin
            gap_cnt <= 4'h0;
         end else if (bit_tick && gap_cnt != `BCF_GAP_MAX) begin
            gap_cnt <= gap_cnt + 4'h1;
         end
         gap_ok <= !frame_end && (gap_cnt >= gap_bits(applied[`BCF_CTRL_GAP_HI:`BCF_CTRL_GAP_LO]));
      end
   end

   // engine-facing control outputs
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         driver_enable <= 1'b0;
         loopback_active <= 1'b0;
         buffers_reset <= 1'b1;
         transfer_abort <= 1'b0;
         message_size_select <= 1'b0;
         interframe_gap_select <= 2'h0;
      end else begin
         driver_enable <= en && !ts && !signal_shutdown_disable_flag && !idle_current_limit_flag && !loop_on && !therm_evt && !sig_trip;
         loopback_active <= loop_on;
         buffers_reset <= !next_en || therm_evt || sig_trip;
         transfer_abort <= ctrl_wr || therm_evt || sig_trip || (en && !next_en);
         message_size_select <= applied[`BCF_CTRL_MS];
         interframe_gap_select <= applied[`BCF_CTRL_GAP_HI:`BCF_CTRL_GAP_LO];
      end
   end

   // register readback and status byte with fixed trailing bits
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
         status_byte <= `BCF_STAT_RESET;
      end else begin
         if (reg_sel == `BCF_SEL_CTRL) begin
            reg_rdata <= ctrl;
         end else begin
            reg_rdata <= {ts, signal_shutdown_disable_flag, 3'h0, bus_high_switch, bus_low_switch, en};
         end
         status_byte <= {rx_crc_error, tx_empty, signal_shutdown_frame, rx_not_empty,
                         idle_current_limit_flag, 1'b0, 1'b0, 1'b1};
      end
   end

   // previous frame of this enable period ended with a signal-mode over-current
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prev_oc_frame <= 1'b0;
      end else if (!en || therm_evt) begin
         prev_oc_frame <= 1'b0;
      end else if (frame_done) begin
         prev_oc_frame <= frame_overcurrent;
      end
   end

   // checks
   a_fixed_bits: assert property (@(posedge clk) disable iff (!resetn)
      status_byte[1:0] == 2'h1) else $error("status trailing bits wrong");
   a_loop_clears_en: assert property (@(posedge clk) disable iff (!resetn)
      loop_on |=> (!en && loopback_active && !driver_enable))
      else $error("loopback left channel enabled");
   a_therm_shut: assert property (@(posedge clk) disable iff (!resetn)
      therm_evt |=> (ts && !en && ctrl == 8'h00 && buffers_reset && transfer_abort)
      ##1 !driver_enable)
      else $error("thermal shutdown incomplete");
   a_ts_sticky: assert property (@(posedge clk) disable iff (!resetn)
      ts && !(en_wr && !reg_wdata[`BCF_EN_TS]) |=> ts)
      else $error("thermal flag cleared without write");
   a_signal_shutdown_disable_flag_sticky: assert property (@(posedge clk) disable iff (!resetn)
      signal_shutdown_disable_flag && !therm_evt && !(en_wr && !reg_wdata[`BCF_EN_SIGNAL_SHUTDOWN_DISABLE_FLAG]) |=> signal_shutdown_disable_flag)
      else $error("signal shutdown flag cleared without write");
   a_sig_two_frames: assert property (@(posedge clk) disable iff (!resetn)
      en && frame_done && frame_overcurrent && prev_oc_frame && !therm_evt |=> signal_shutdown_disable_flag && !en)
      else $error("two over-current frames did not shut down");
   a_icl_trip: assert property (@(posedge clk) disable iff (!resetn)
      fif.trip && fif.arm |=> idle_current_limit_flag ##1 !driver_enable)
      else $error("idle fault did not drop drivers");
   a_icl_hold: assert property (@(posedge clk) disable iff (!resetn)
      idle_current_limit_flag && en && !therm_evt |=> idle_current_limit_flag) else $error("idle flag cleared while enabled");
   a_write_abort: assert property (@(posedge clk) disable iff (!resetn)
      ctrl_wr |=> transfer_abort) else $error("control write did not abort");
   a_switch_open: assert property (@(posedge clk) disable iff (!resetn)
      (sw_therm || (!en && !en_wr)) |=> !bus_high_switch && !bus_low_switch)
      else $error("switch left closed");
   a_disable_reset: assert property (@(posedge clk) disable iff (!resetn)
      !en && !en_wr |=> buffers_reset) else $error("disabled channel buffers not reset");
   a_gap_min: assert property (@(posedge clk) disable iff (!resetn)
      frame_end |=> (!gap_ok)[*4]) else $error("gap granted too early");
   c_therm: cover property (@(posedge clk) disable iff (!resetn) therm_evt);
   c_icl: cover property (@(posedge clk) disable iff (!resetn) $rose(idle_current_limit_flag));
   c_loop: cover property (@(posedge clk) disable iff (!resetn) $rose(loopback_active));
   c_signal_shutdown_disable_flag: cover property (@(posedge clk) disable iff (!resetn) $rose(signal_shutdown_disable_flag));
endmodule
`default_nettype wire

// *** include/bcf_map.svh ***
// bcf_map.svh: register fields, reset values and timing counts for the channel
// control and fault block.
// assumes a 10 MHz clk; counts are derived from the period below.
`ifndef BCF_MAP_SVH
`define BCF_MAP_SVH

// clock period and documented fault times
`define BCF_CLK_PERIOD_NS 100
`define BCF_IDLE_PERSIST_NS 2500
`define BCF_IDLE_SEP_NS 50000
`define BCF_THERM_FILT_NS 4000

// least times round up, longest times round down
`define BCF_IDLE_PERSIST_CYC ((`BCF_IDLE_PERSIST_NS + `BCF_CLK_PERIOD_NS - 1) / `BCF_CLK_PERIOD_NS)
`define BCF_IDLE_SEP_CYC (`BCF_IDLE_SEP_NS / `BCF_CLK_PERIOD_NS)
`define BCF_THERM_FILT_CYC ((`BCF_THERM_FILT_NS + `BCF_CLK_PERIOD_NS - 1) / `BCF_CLK_PERIOD_NS)
`define BCF_IDLE_OCCUR_COUNT 4
`define BCF_SIG_OC_FRAMES 2

// register select codes on the register port
`define BCF_SEL_CTRL 1'b0
`define BCF_SEL_EN 1'b1

// reset values
`define BCF_CTRL_RESET 8'h00
`define BCF_EN_RESET 8'h00
`define BCF_STAT_RESET 8'h41

// channel_control fields
`define BCF_CTRL_MS 0
`define BCF_CTRL_LOOP_LO 1
`define BCF_CTRL_LOOP_HI 2
`define BCF_CTRL_GAP_LO 4
`define BCF_CTRL_GAP_HI 5
`define BCF_LOOP_ON 2'h3

// channel_enable_fault fields
`define BCF_EN_EN 0
`define BCF_EN_LOW 1
`define BCF_EN_HIGH 2
`define BCF_EN_SIGNAL_SHUTDOWN_DISABLE_FLAG 6
`define BCF_EN_TS 7

// status byte fields
`define BCF_ST_FIXED_ONE_BIT 0
`define BCF_ST_FIXED_ZERO_BIT 1
`define BCF_ST_ICL 3

// interframe gap in bit times per select code
`define BCF_GAP_SEL0 4'h4
`define BCF_GAP_SEL1 4'h5
`define BCF_GAP_SEL2 4'h6
`define BCF_GAP_SEL3 4'h8
`define BCF_GAP_MAX 4'h8

`endif

// *** include/bcf_pkg.sv ***
// bcf_pkg: types shared by the channel control and fault block.
// assumes bcf_map.svh holds all numbers.
`default_nettype none
package bcf_pkg;
   typedef logic [7:0] bcf_byte_t;
   typedef logic [3:0] bcf_bits_t;
   typedef enum logic [1:0] {BCF_IDLE_CLEAR, BCF_IDLE_FAULT, BCF_IDLE_TRIPPED} bcf_idle_st_e;
endpackage
`default_nettype wire

// *** include/bcf_fault_if.sv ***
// bcf_fault_if: arm and trip between the channel logic and the idle fault monitor.
// assumes both ends run on the same clk.
`default_nettype none
interface bcf_fault_if;
   logic arm;
   logic trip;
   modport mon (input arm, output trip);
   modport ctl (output arm, input trip);
endinterface
`default_nettype wire

// *** core/bcf_idle_fault.sv ***
// bcf_idle_fault: qualifies the idle-mode over-current pin into a trip pulse.
// assumes the pin is asynchronous to clk; arm low holds the monitor cleared.
`include "bcf_map.svh"
`default_nettype none
module bcf_idle_fault #(
   parameter int PERSIST_CYC = `BCF_IDLE_PERSIST_CYC,
   parameter int SEP_CYC = `BCF_IDLE_SEP_CYC
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic idle_overcurrent,
   bcf_fault_if.mon fif
);
   localparam int PW = $clog2(PERSIST_CYC + 1);
   localparam int SW = $clog2(SEP_CYC + 2);
   logic s1, s2, s3, lvl;
   logic [PW-1:0] per_cnt;
   logic [SW-1:0] sep_cnt;
   logic [2:0] occ;
   logic [2:0] next_occ;
   bcf_pkg::bcf_idle_st_e state;

   // three-stage synchroniser, level taken once stages two and three agree
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         lvl <= 1'b0;
      end else begin
         s1 <= idle_overcurrent;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            lvl <= s3;
         end
      end
   end

   // occurrence count if this onset lands within the separation window
   always_comb begin
      next_occ = 3'h1;
      if (occ != 3'h0 && sep_cnt <= SW'(SEP_CYC)) begin
         next_occ = occ + 3'h1;
      end
   end

   // fault qualification: persistence or repeated onsets
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= bcf_pkg::BCF_IDLE_CLEAR;
         per_cnt <= '0;
         sep_cnt <= '0;
         occ <= 3'h0;
         fif.trip <= 1'b0;
      end else if (!fif.arm) begin
         state <= bcf_pkg::BCF_IDLE_CLEAR;
         per_cnt <= '0;
         sep_cnt <= '0;
         occ <= 3'h0;
         fif.trip <= 1'b0;
      end else begin
         fif.trip <= 1'b0;
         unique case (state)
            bcf_pkg::BCF_IDLE_CLEAR: begin
               if (sep_cnt <= SW'(SEP_CYC)) begin
                  sep_cnt <= sep_cnt + SW'(1);
               end
               if (lvl) begin
                  per_cnt <= PW'(1);
                  occ <= next_occ;
                  if (next_occ == 3'(`BCF_IDLE_OCCUR_COUNT)) begin
                     fif.trip <= 1'b1;
                     state <= bcf_pkg::BCF_IDLE_TRIPPED;
                  end else begin
                     state <= bcf_pkg::BCF_IDLE_FAULT;
                  end
               end
            end
            bcf_pkg::BCF_IDLE_FAULT: begin
               if (!lvl) begin
                  sep_cnt <= '0;
                  state <= bcf_pkg::BCF_IDLE_CLEAR;
               end else if (per_cnt == PW'(PERSIST_CYC - 1)) begin
                  fif.trip <= 1'b1;
                  state <= bcf_pkg::BCF_IDLE_TRIPPED;
               end else begin
                  per_cnt <= per_cnt + PW'(1);
               end
            end
            bcf_pkg::BCF_IDLE_TRIPPED: begin
               state <= bcf_pkg::BCF_IDLE_TRIPPED;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// *** testbench/bcf_engine_model.sv ***
// bcf_engine_model: protocol engine and far bus side for one channel.
// assumes start is a one-cycle request from the bench on clk.
`default_nettype none
module bcf_engine_model (
   input wire logic clk,
   input wire logic resetn,
   input wire logic start,
   input wire logic oc,
   output logic frame_active,
   output logic frame_end,
   output logic frame_overcurrent,
   output logic bit_tick
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] div;
   logic [2:0] bits;
   logic oc_q;
   // bit ticks run free; a frame lasts four bit times and ends off a tick
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         div <= 2'h0;
         bits <= 3'h0;
         oc_q <= 1'b0;
         frame_active <= 1'b0;
         frame_end <= 1'b0;
         frame_overcurrent <= 1'b0;
         bit_tick <= 1'b0;
      end else begin
         div <= div + 2'h1;
         bit_tick <= (div == 2'h3);
         frame_end <= 1'b0;
         // the flag means nothing off a frame end, so show the opposite
         frame_overcurrent <= ~oc_q;
         if (start && !frame_active) begin
            frame_active <= 1'b1;
            bits <= 3'h0;
            oc_q <= oc;
         end else if (frame_active && bit_tick) begin
            bits <= bits + 3'h1;
         end
         if (frame_active && bits == 3'h4 && div == 2'h1) begin
            frame_active <= 1'b0;
            frame_end <= 1'b1;
            frame_overcurrent <= oc_q;
         end
      end
   end
endmodule
`default_nettype wire

// *** testbench/bus_channel_control_fault_tb.sv ***
// bus_channel_control_fault_tb: self-checking bench of the channel block.
// assumes the engine model stands in for the protocol engine and bus.
`default_nettype none
module bus_channel_control_fault_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, resetn, reg_wr, reg_sel, start, oc;
   logic [7:0] reg_wdata, reg_rdata, status_byte;
   logic idle_overcurrent, driver_thermal, switch_thermal;
   logic frame_active, frame_end, frame_overcurrent, bit_tick;
   logic [3:0] st_in;
   logic driver_enable, loopback_active, bus_high_switch, bus_low_switch;
   logic buffers_reset, transfer_abort, message_size_select, gap_ok;
   logic [1:0] interframe_gap_select;
   wire logic [7:0] outs;
   logic wr_abort;
   int fails = 0;
   int n_tests = 0;
   bcf_channel #(.THERM_FILT_CYC(4)) dut (.clk, .resetn, .reg_wr, .reg_sel, .reg_wdata,
      .reg_rdata, .status_byte, .idle_overcurrent, .driver_thermal, .switch_thermal,
      .frame_active, .frame_end, .frame_done(frame_end), .frame_overcurrent, .bit_tick,
      .rx_crc_error(st_in[3]), .tx_empty(st_in[2]), .signal_shutdown_frame(st_in[1]),
      .rx_not_empty(st_in[0]), .driver_enable, .loopback_active, .bus_high_switch,
      .bus_low_switch, .buffers_reset, .transfer_abort, .message_size_select,
      .interframe_gap_select, .gap_ok);
   bcf_engine_model far (.clk, .resetn, .start, .oc, .frame_active, .frame_end,
      .frame_overcurrent, .bit_tick);
   // output levels gathered for masked polling
   assign outs = {driver_enable, loopback_active, bus_high_switch, bus_low_switch,
      buffers_reset, transfer_abort, gap_ok, message_size_select};
   // clock generator
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic conclude();
      if (fails == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] want);
      n_tests++;
      if (seen !== want) begin
         fails++;
         $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic wr(input logic sel, input logic [7:0] d);
      reg_sel = sel;
      reg_wdata = d;
      reg_wr = 1'b1;
      step();
      wr_abort = transfer_abort;
      reg_wr = 1'b0;
      step();
   endtask
   // bounded wait for a masked value: 0 readback, 1 status, 2 outputs
   task automatic poll(input int w, input logic [7:0] m, input logic [7:0] v);
      logic [7:0] s;
      for (int i = 0; i < 300; i++) begin
         s = (w == 0) ? reg_rdata : (w == 1) ? status_byte : outs;
         if ((s & m) === v) break;
         step();
      end
      chk(s & m, v);
      if ((s & m) !== v) conclude();
   endtask
   task automatic rd(input logic sel, input logic [7:0] m, input logic [7:0] v);
      reg_sel = sel;
      step();
      step();
      poll(0, m, v);
   endtask
   // one frame; returns once its end is visible
   task automatic frame(input logic o);
      oc = o;
      start = 1'b1;
      step();
      start = 1'b0;
      for (int i = 0; i < 300 && frame_end !== 1'b1; i++) step();
      if (frame_end !== 1'b1) begin
         fails++;
         conclude();
      end
   endtask
   task automatic t_reset();
      rd(1'b0, 8'hff, 8'h00);
      rd(1'b1, 8'hff, 8'h00);
      poll(1, 8'hff, 8'h41);
      poll(2, 8'h88, 8'h08);
      st_in = 4'hb;
      poll(1, 8'hff, 8'hb1);
      st_in = 4'h4;
   endtask
   task automatic t_switch();
      wr(1'b1, 8'h07);
      rd(1'b1, 8'hff, 8'h07);
      poll(2, 8'hf8, 8'hb0);
      wr(1'b1, 8'h03);
      rd(1'b1, 8'hff, 8'h03);
      wr(1'b1, 8'h06);
      rd(1'b1, 8'hff, 8'h00);
      poll(2, 8'h38, 8'h08);
   endtask
   task automatic t_loop();
      for (int v = 0; v < 4; v++) begin
         wr(1'b1, 8'h01);
         wr(1'b0, {5'h0, v[1:0], 1'b0});
         chk({7'h0, wr_abort}, 8'h01);
         rd(1'b1, 8'h01, (v == 3) ? 8'h00 : 8'h01);
         poll(2, 8'hc0, (v == 3) ? 8'h40 : 8'h80);
      end
      wr(1'b0, 8'h00);
   endtask
   task automatic t_gap();
      int n;
      logic [7:0] gaps [4] = '{8'h04, 8'h05, 8'h06, 8'h08};
      for (int g = 0; g < 4; g++) begin
         wr(1'b0, {2'h0, g[1:0], 3'h0, g[0]});
         wr(1'b1, 8'h01);
         frame(1'b0);
         n = 0;
         step();
         for (int i = 0; i < 300 && gap_ok !== 1'b1; i++) begin
            @(posedge clk);
            n += int'(bit_tick);
            #1;
         end
         chk(n[7:0], gaps[g]);
         chk({7'h0, message_size_select}, {7'h0, g[0]});
         chk({6'h0, interframe_gap_select}, g[7:0]);
      end
   endtask
   task automatic t_therm();
      wr(1'b0, 8'h31);
      wr(1'b1, 8'h07);
      driver_thermal = 1'b1;
      poll(0, 8'hff, 8'h80);
      poll(2, 8'h88, 8'h08);
      driver_thermal = 1'b0;
      rd(1'b0, 8'hff, 8'h00);
      wr(1'b1, 8'h80);
      rd(1'b1, 8'hff, 8'h80);
      wr(1'b1, 8'h01);
      rd(1'b1, 8'hff, 8'h01);
      poll(2, 8'h80, 8'h80);
   endtask
   task automatic t_swth();
      wr(1'b0, 8'h21);
      wr(1'b1, 8'h07);
      switch_thermal = 1'b1;
      poll(0, 8'hff, 8'h01);
      switch_thermal = 1'b0;
      rd(1'b0, 8'hff, 8'h21);
      poll(2, 8'h80, 8'h80);
   endtask
   task automatic t_sig();
      wr(1'b0, 8'h10);
      wr(1'b1, 8'h07);
      frame(1'b1);
      frame(1'b0);
      frame(1'b1);
      rd(1'b1, 8'hff, 8'h07);
      frame(1'b1);
      poll(0, 8'hff, 8'h40);
      rd(1'b0, 8'hff, 8'h10);
      wr(1'b1, 8'h40);
      rd(1'b1, 8'hff, 8'h40);
      wr(1'b1, 8'h00);
      rd(1'b1, 8'hff, 8'h00);
   endtask
   task automatic t_idle();
      wr(1'b1, 8'h01);
      idle_overcurrent = 1'b1;
      poll(1, 8'h08, 8'h08);
      poll(2, 8'h80, 8'h00);
      idle_overcurrent = 1'b0;
      repeat (30) step();
      chk(status_byte & 8'h08, 8'h08);
      wr(1'b1, 8'h00);
      poll(1, 8'h08, 8'h00);
      wr(1'b1, 8'h01);
      for (int i = 0; i < 4; i++) begin
         chk(status_byte & 8'h08, 8'h00);
         idle_overcurrent = 1'b1;
         repeat (5) step();
         idle_overcurrent = 1'b0;
         repeat (20) step();
      end
      poll(1, 8'h08, 8'h08);
   endtask
   // reset, then the scenarios in turn
   initial begin
      resetn = 1'b0;
      reg_wr = 1'b0;
      reg_sel = 1'b0;
      reg_wdata = 8'h00;
      start = 1'b0;
      oc = 1'b0;
      idle_overcurrent = 1'b0;
      driver_thermal = 1'b0;
      switch_thermal = 1'b0;
      st_in = 4'h4;
      repeat (16) @(posedge clk);
      #1;
      resetn = 1'b1;
      t_reset();
      t_switch();
      t_loop();
      t_gap();
      t_therm();
      t_swth();
      t_sig();
      t_idle();
      conclude();
   end
endmodule
`default_nettype wire
